// ### src/rps_pkg.sv
package rps_pkg;

  localparam int NUM_PINS = 44;
  localparam int NUM_BIDIR = 32;
  localparam int NUM_IN = 33;
  localparam int SEL_W = 6;
  localparam int PIN_IDX_W = 5;
  localparam int NUM_FUNC = 38;
  localparam int SEL_SPACE = 64;

  localparam logic [5:0] MAX_PIN = 6'h2b;
  localparam logic [5:0] SEL_RESET = 6'h3f;
  localparam logic [5:0] FUNC_NULL = 6'h00;
  localparam logic [5:0] RD_NONE = 6'h00;

  localparam logic [NUM_PINS-1:0] PIN_IMPL_ALL = 44'hfff_ffff_ffff;

  // Output function codes that have a source; all others act as null.
  localparam logic [63:0] FUNC_VALID = 64'h0000_0038_f3fc_1ffe;

  // Comparator output codes, routed like any other digital output.
  localparam logic [5:0] FUNC_CMP1 = 6'h01;
  localparam logic [5:0] FUNC_CMP2 = 6'h02;
  localparam logic [5:0] FUNC_CMP3 = 6'h24;

  // Peripheral input slots, in selector index order.
  localparam logic [5:0] IN_MOD_DATA = 6'h00;
  localparam logic [5:0] IN_CARRIER1 = 6'h01;
  localparam logic [5:0] IN_CARRIER2 = 6'h02;
  localparam logic [5:0] IN_EXT_IRQ1 = 6'h03;
  localparam logic [5:0] IN_EXT_IRQ4 = 6'h06;
  localparam logic [5:0] IN_CAPTURE1 = 6'h07;
  localparam logic [5:0] IN_CAPTURE9 = 6'h0f;
  localparam logic [5:0] IN_FAULT_A = 6'h10;
  localparam logic [5:0] IN_FAULT_B = 6'h11;
  localparam logic [5:0] IN_SPI1_CLK = 6'h12;
  localparam logic [5:0] IN_SPI1_DATA = 6'h13;
  localparam logic [5:0] IN_SPI1_SEL = 6'h14;
  localparam logic [5:0] IN_SPI2_CLK = 6'h15;
  localparam logic [5:0] IN_SPI2_DATA = 6'h16;
  localparam logic [5:0] IN_SPI2_SEL = 6'h17;
  localparam logic [5:0] IN_TIMER_CLK = 6'h18;
  localparam logic [5:0] IN_UART1_CTS = 6'h19;
  localparam logic [5:0] IN_UART1_RX = 6'h1a;
  localparam logic [5:0] IN_UART2_CTS = 6'h1b;
  localparam logic [5:0] IN_UART2_RX = 6'h1c;
  localparam logic [5:0] IN_UART3_CTS = 6'h1d;
  localparam logic [5:0] IN_UART3_RX = 6'h1e;
  localparam logic [5:0] IN_UART4_CTS = 6'h1f;
  localparam logic [5:0] IN_UART4_RX = 6'h20;

  // Idle level per input: selects, clear-to-send and receive idle high.
  localparam logic [NUM_IN-1:0] IN_IDLE = 33'h1_fe90_0000;

endpackage : rps_pkg

// ### src/rps_sync.sv
`timescale 1ns/100ps
`default_nettype none

module rps_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : rps_sync

`default_nettype wire

// ### src/rps_crossbar.sv
`timescale 1ns/100ps
`default_nettype none

module rps_crossbar #(
  parameter logic [rps_pkg::NUM_PINS-1:0] PIN_IMPL = rps_pkg::PIN_IMPL_ALL
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Routing lock
  input wire logic routing_write_lock_in,
  // Input selector write and readback
  input wire logic sel_wr_en_in,
  input wire logic [rps_pkg::SEL_W-1:0] sel_wr_index_in,
  input wire logic [rps_pkg::SEL_W-1:0] sel_wr_data_in,
  input wire logic [rps_pkg::SEL_W-1:0] sel_rd_index_in,
  output logic [rps_pkg::SEL_W-1:0] sel_rd_data_out,
  // Output map write and readback
  input wire logic map_wr_en_in,
  input wire logic [rps_pkg::PIN_IDX_W-1:0] map_wr_pin_in,
  input wire logic [rps_pkg::SEL_W-1:0] map_wr_code_in,
  input wire logic [rps_pkg::PIN_IDX_W-1:0] map_rd_pin_in,
  output logic [rps_pkg::SEL_W-1:0] map_rd_code_out,
  // Pins
  input wire logic [rps_pkg::NUM_PINS-1:0] pin_level_in,
  input wire logic [rps_pkg::NUM_PINS-1:0] pin_analog_en_in,
  output logic [rps_pkg::NUM_BIDIR-1:0] pin_data_out,
  output logic [rps_pkg::NUM_BIDIR-1:0] pin_oe_out,
  // Pin owners other than the crossbar
  input wire logic [rps_pkg::NUM_BIDIR-1:0] port_direction_control_in,
  input wire logic [rps_pkg::NUM_BIDIR-1:0] port_data_in,
  input wire logic [rps_pkg::NUM_BIDIR-1:0] gp_oe_in,
  input wire logic [rps_pkg::NUM_BIDIR-1:0] gp_data_in,
  input wire logic [rps_pkg::NUM_BIDIR-1:0] special_oe_in,
  input wire logic [rps_pkg::NUM_BIDIR-1:0] special_data_in,
  // Peripheral side
  input wire logic [rps_pkg::NUM_FUNC-1:0] periph_src_in,
  output logic [rps_pkg::NUM_IN-1:0] periph_input_out,
  output logic [rps_pkg::NUM_IN-1:0] periph_connected_out,
  output logic [rps_pkg::NUM_BIDIR-1:0] pin_remapped_out
);

  localparam int NUM_PINS = rps_pkg::NUM_PINS;
  localparam int NUM_BIDIR = rps_pkg::NUM_BIDIR;
  localparam int NUM_IN = rps_pkg::NUM_IN;
  localparam int SEL_W = rps_pkg::SEL_W;
  localparam int PIN_IDX_W = rps_pkg::PIN_IDX_W;
  localparam int SPACE = rps_pkg::SEL_SPACE;
  localparam int PAD_PIN = rps_pkg::SEL_SPACE - rps_pkg::NUM_PINS;
  localparam int PAD_FUNC = rps_pkg::SEL_SPACE - rps_pkg::NUM_FUNC;
  localparam logic [SEL_W-1:0] IN_LAST = SEL_W'(NUM_IN - 1);

  // Synchronised pin levels.
  logic [NUM_PINS-1:0] pin_sync;

  rps_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(pin_level_in),
    .sync_out(pin_sync)
  );

  // Pins in analog mode present zero to the crossbar.
  wire [NUM_PINS-1:0] pin_digital = pin_sync & ~pin_analog_en_in;
  wire [SPACE-1:0] pin_ext = {{PAD_PIN{1'b0}}, pin_digital};
  wire [SPACE-1:0] impl_ext = {{PAD_PIN{1'b0}}, PIN_IMPL};
  wire [SPACE-1:0] src_ext = {{PAD_FUNC{1'b0}}, periph_src_in};

  // Write qualification; a locked write is accepted and discarded.
  wire writes_open = !routing_write_lock_in;
  wire sel_idx_ok = sel_wr_index_in <= IN_LAST;
  wire sel_wr_ok = sel_wr_en_in && writes_open && sel_idx_ok;
  wire map_pin_ok = PIN_IMPL[map_wr_pin_in];
  wire map_wr_ok = map_wr_en_in && writes_open && map_pin_ok;

  wire sel_rd_ok = sel_rd_index_in <= IN_LAST;

  // Input routing: one selector per peripheral input.
  logic [SEL_W-1:0] sel_reg [NUM_IN];
  logic [NUM_IN-1:0] in_data_next;
  logic [NUM_IN-1:0] in_conn_next;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1)
    begin : g_in
      wire [SEL_W-1:0] sel = sel_reg[gi];
      wire hit = sel_wr_ok && (sel_wr_index_in == SEL_W'(gi));
      // Values above the last pin or on a missing pin are invalid.
      wire valid = (sel <= rps_pkg::MAX_PIN) && impl_ext[sel];
      wire idle = rps_pkg::IN_IDLE[gi];

      assign in_conn_next[gi] = valid;
      // Pin n feeds this input when the selector holds n.
      assign in_data_next[gi] = valid ? pin_ext[sel] : idle;

      // Reset leaves every input unassigned.
      always_ff @(posedge core_clk_in)
      begin
        if (!reset_n_in)
          sel_reg[gi] <= rps_pkg::SEL_RESET;
        else if (hit)
          sel_reg[gi] <= sel_wr_data_in;
      end
    end
  endgenerate

  // Output routing: one function code per bidirectional pin.
  logic [SEL_W-1:0] code_reg [NUM_BIDIR];
  logic [NUM_BIDIR-1:0] pin_data_next;
  logic [NUM_BIDIR-1:0] pin_oe_next;
  logic [NUM_BIDIR-1:0] remap_next;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_BIDIR; gp = gp + 1)
    begin : g_pin
      wire [SEL_W-1:0] code = code_reg[gp];
      wire hit = map_wr_ok && (map_wr_pin_in == PIN_IDX_W'(gp));
      wire remap_on = PIN_IMPL[gp] && rps_pkg::FUNC_VALID[code];
      wire remap_bit = src_ext[code];
      // Direction for a remapped pin still follows the port setting.
      wire remap_oe = port_direction_control_in[gp];
      wire gp_own = gp_oe_in[gp];
      wire base_data = gp_own ? gp_data_in[gp] : port_data_in[gp];
      wire base_oe = gp_own | port_direction_control_in[gp];
      wire low_data = remap_on ? remap_bit : base_data;
      wire low_oe = remap_on ? remap_oe : base_oe;

      assign remap_next[gp] = remap_on && !special_oe_in[gp];
      assign pin_data_next[gp] = special_oe_in[gp] ? special_data_in[gp]
                                                   : low_data;
      assign pin_oe_next[gp] = special_oe_in[gp] | low_oe;

      always_ff @(posedge core_clk_in)
      begin
        if (!reset_n_in)
          code_reg[gp] <= rps_pkg::FUNC_NULL;
        else if (hit)
          code_reg[gp] <= map_wr_code_in;
      end
    end
  endgenerate

  // Input-only pins have no output path at all; only their level is used.
  wire [SEL_W-1:0] sel_rd_next = sel_rd_ok ? sel_reg[sel_rd_index_in]
                                           : rps_pkg::RD_NONE;
  wire [SEL_W-1:0] map_rd_next = code_reg[map_rd_pin_in];

  // Registered outputs keep the peripheral inputs glitch free.
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      periph_input_out <= rps_pkg::IN_IDLE;
      periph_connected_out <= '0;
    end
    else
    begin
      periph_input_out <= in_data_next;
      periph_connected_out <= in_conn_next;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      pin_data_out <= '0;
      pin_oe_out <= '0;
      pin_remapped_out <= '0;
    end
    else
    begin
      pin_data_out <= pin_data_next;
      pin_oe_out <= pin_oe_next;
      pin_remapped_out <= remap_next;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      sel_rd_data_out <= rps_pkg::RD_NONE;
      map_rd_code_out <= rps_pkg::FUNC_NULL;
    end
    else
    begin
      sel_rd_data_out <= sel_rd_next;
      map_rd_code_out <= map_rd_next;
    end
  end

  // Fixed-function groups never enter this block, so nothing routes them.

endmodule : rps_crossbar

`default_nettype wire

// ### bench/rps_crossbar_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rps_crossbar_properties (
  // Clock, reset and lock
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic routing_write_lock_in,
  // Configuration
  input wire logic sel_wr_en_in,
  input wire logic [5:0] sel_wr_index_in,
  input wire logic [5:0] sel_wr_data_in,
  input wire logic [5:0] sel_rd_index_in,
  input wire logic [5:0] sel_rd_data_out,
  input wire logic map_wr_en_in,
  input wire logic [4:0] map_wr_pin_in,
  input wire logic [5:0] map_wr_code_in,
  input wire logic [4:0] map_rd_pin_in,
  input wire logic [5:0] map_rd_code_out,
  // Pins and owners
  input wire logic [31:0] pin_data_out,
  input wire logic [31:0] pin_oe_out,
  input wire logic [31:0] port_direction_control_in,
  input wire logic [31:0] gp_oe_in,
  input wire logic [31:0] special_oe_in,
  input wire logic [31:0] special_data_in,
  input wire logic [31:0] pin_remapped_out,
  // Peripheral side
  input wire logic [32:0] periph_input_out,
  input wire logic [32:0] periph_connected_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_special_wins: assert property (special_oe_in[3] |=> pin_oe_out[3]
    && pin_data_out[3] == $past(special_data_in[3]))
    else $error("special output lost its pin");
  a_no_input_oe: assert property ((pin_oe_out & ~$past(special_oe_in
    | gp_oe_in | port_direction_control_in)) == 32'h0000_0000)
    else $error("pin driven with no owner");
  a_remap_over_gp: assert property (pin_remapped_out[3]
    && !$past(special_oe_in[3])
    |-> pin_oe_out[3] == $past(port_direction_control_in[3]))
    else $error("remapped pin took wrong enable");
  a_idle_level: assert property (((periph_input_out ^ rps_pkg::IN_IDLE)
    & ~periph_connected_out) == 33'h0_0000_0000)
    else $error("unconnected input not idle");
  a_sel_write: assert property (sel_wr_en_in && !routing_write_lock_in
    && sel_wr_index_in <= 6'h20 ##1 sel_rd_index_in == $past(sel_wr_index_in)
    |=> sel_rd_data_out == $past(sel_wr_data_in, 2))
    else $error("selector write not stored");
  a_sel_locked: assert property (routing_write_lock_in
    && $past(routing_write_lock_in) && $past(reset_n_in)
    && sel_rd_index_in == $past(sel_rd_index_in) |=> $stable(sel_rd_data_out))
    else $error("selector changed under lock");
  a_map_locked: assert property (routing_write_lock_in
    && $past(routing_write_lock_in) && $past(reset_n_in)
    && map_rd_pin_in == $past(map_rd_pin_in) |=> $stable(map_rd_code_out))
    else $error("output map changed under lock");
  a_bad_sel: assert property (sel_wr_en_in && !routing_write_lock_in
    && sel_wr_index_in == 6'h1a && sel_wr_data_in > 6'h2b
    |=> ##1 !periph_connected_out[26])
    else $error("invalid selector connected");
  a_null_code: assert property (map_wr_en_in && !routing_write_lock_in
    && map_wr_pin_in == 5'h03 && map_wr_code_in == 6'h00
    |=> ##1 !pin_remapped_out[3])
    else $error("null code still remapped");
endmodule : rps_crossbar_properties
bind rps_crossbar rps_crossbar_properties u_props (.*);
`default_nettype wire

// ### bench/rps_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module rps_far_model (
  // Pin drive and board levels
  input wire logic [31:0] pin_data_in,
  input wire logic [31:0] pin_oe_in,
  input wire logic [43:0] ext_level_in,
  output logic [43:0] pin_level_out
);
  // A driven pin reads its own drive, so input routing sees the true wire.
  assign pin_level_out = {ext_level_in[43:32],
    (pin_oe_in & pin_data_in) | (~pin_oe_in & ext_level_in[31:0])};
endmodule : rps_far_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lock = 1'b0;
  logic sel_en = 1'b0;
  logic map_en = 1'b0;
  logic [5:0] sel_idx = '0, sel_dat = '0, rd_idx = '0, map_code = '0;
  logic [5:0] sel_rd, map_rd;
  logic [4:0] map_pin = '0, map_rdp = '0;
  logic [43:0] ext = '0, ana = '0, lvl;
  logic [31:0] dir = '0, pdat = '0, gpoe = '0, gpd = '0, spoe = '0, spd = '0;
  logic [31:0] dout, oe, remap;
  logic [37:0] src = '0;
  logic [32:0] pin_in, conn;
  int checks = 0;
  int n_fail = 0;
  // Pin 42 is left out, as a smaller package would do.
  localparam logic [43:0] IMPL = 44'hbff_ffff_ffff;
  initial forever #2.5 clk = ~clk;
  rps_far_model far (.pin_data_in(dout), .pin_oe_in(oe), .ext_level_in(ext),
    .pin_level_out(lvl));
  rps_crossbar #(.PIN_IMPL(IMPL)) dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .routing_write_lock_in(lock), .sel_wr_en_in(sel_en),
    .sel_wr_index_in(sel_idx), .sel_wr_data_in(sel_dat),
    .sel_rd_index_in(rd_idx), .sel_rd_data_out(sel_rd),
    .map_wr_en_in(map_en), .map_wr_pin_in(map_pin), .map_wr_code_in(map_code),
    .map_rd_pin_in(map_rdp), .map_rd_code_out(map_rd), .pin_level_in(lvl),
    .pin_analog_en_in(ana), .pin_data_out(dout), .pin_oe_out(oe),
    .port_direction_control_in(dir), .port_data_in(pdat), .gp_oe_in(gpoe),
    .gp_data_in(gpd), .special_oe_in(spoe), .special_data_in(spd),
    .periph_src_in(src), .periph_input_out(pin_in),
    .periph_connected_out(conn), .pin_remapped_out(remap));
  task automatic chk(input logic [63:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic wsel(input logic [5:0] i, d);
    @(posedge clk);
    sel_en <= 1'b1;
    sel_idx <= i;
    sel_dat <= d;
    rd_idx <= i;
    @(posedge clk);
    sel_en <= 1'b0;
    w(3);
  endtask : wsel
  task automatic wmap(input logic [4:0] p, input logic [5:0] c);
    @(posedge clk);
    map_en <= 1'b1;
    map_pin <= p;
    map_code <= c;
    map_rdp <= p;
    @(posedge clk);
    map_en <= 1'b0;
    w(3);
  endtask : wmap
  task automatic t_route_in();
    @(posedge clk);
    ext[5] <= 1'b1;
    wsel(6'h1a, 6'h05);
    wsel(6'h03, 6'h28);
    chk(sel_rd, 6'h28);
    chk({pin_in[26], pin_in[3], conn[26], conn[3], oe[5]}, 5'b10110);
    @(posedge clk);
    ext[5] <= 1'b0;
    ext[40] <= 1'b1;
    w(4);
    chk({pin_in[26], pin_in[3]}, 2'b01);
    @(posedge clk);
    ana[5] <= 1'b1;
    ext[5] <= 1'b1;
    w(4);
    chk(pin_in[26], 1'b0);
    @(posedge clk);
    ana[5] <= 1'b0;
    w(2);
    chk(pin_in[26], 1'b1);
  endtask : t_route_in
  task automatic t_bad_and_lock();
    wsel(6'h1a, 6'h2a);
    chk(conn[26], 1'b0);
    wsel(6'h1a, 6'h2c);
    chk({conn[26], pin_in[26]}, {1'b0, rps_pkg::IN_IDLE[26]});
    @(posedge clk);
    lock <= 1'b1;
    wsel(6'h1a, 6'h07);
    chk(sel_rd, 6'h2c);
    wmap(5'h03, 6'h01);
    chk(map_rd, 6'h00);
    @(posedge clk);
    lock <= 1'b0;
  endtask : t_bad_and_lock
  task automatic t_out();
    @(posedge clk);
    dir[3] <= 1'b1;
    gpoe[3] <= 1'b1;
    src <= 38'h10_0000_0002;
    wmap(5'h03, 6'h01);
    chk({dout[3], oe[3], remap[3], map_rd}, {3'b111, 6'h01});
    @(posedge clk);
    src <= 38'h10_0000_0000;
    wmap(5'h03, 6'h24);
    chk({dout[3], remap[3]}, 2'b11);
    @(posedge clk);
    spoe[3] <= 1'b1;
    w(2);
    chk({dout[3], oe[3]}, 2'b01);
    @(posedge clk);
    spoe[3] <= 1'b0;
    wmap(5'h03, 6'h00);
    chk({dout[3], oe[3], remap[3]}, 3'b010);
  endtask : t_out
  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    w(1);
    chk(pin_in, rps_pkg::IN_IDLE);
    chk(conn, 33'h0_0000_0000);
    t_route_in();
    t_bad_and_lock();
    t_out();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
